// ---- bench/adcets_core_model.sv ----
// behavioural analog core that answers start pulses with results
`timescale 1ns/1ps
`default_nettype none
module adcets_core_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic [1:0] conv_channel,
  input  wire logic       slow,
  input  wire logic       stray,
  output var  logic       conv_done,
  output var  logic [9:0] conv_data,
  output var  logic [7:0] done_count
);
  // ************************************************
  // conversion timer
  // ************************************************
  int         left;
  logic [9:0] held;
  logic [9:0] noise;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      left = 0;
      conv_done <= 1'b0;
      done_count <= 8'h00;
      held <= 10'h000;
      noise <= 10'h2a5;
    end else begin
      conv_done <= 1'b0;
      noise <= noise + 10'h13b;
      // stray mode keeps a cancelled conversion alive so a late answer reaches the block
      if (conv_abort && !stray) left = 0;
      if (conv_start) begin
        left = slow ? 20 : 2;
        held <= {conv_channel, done_count};
      end else if (left == 1) begin
        conv_done <= 1'b1;
        done_count <= done_count + 8'h01;
        left = 0;
      end else if (left > 1) begin
        left = left - 1;
      end
    end
  end
  // data only means something in the done cycle, so it is scrambled elsewhere
  assign conv_data = conv_done ? held : noise;
endmodule
`default_nettype wire

// ---- bench/adcets_properties.sv ----
// assertion checker for the external trigger conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcets_properties (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       conv_start,
  input wire logic       conv_abort,
  input wire logic       conv_done,
  input wire logic       conversion_end_irq,
  input wire logic       conversion_busy_flag
);
  // ************************************************
  // helper logic
  // ************************************************
  logic [7:0] wr_addr;
  logic       cfg_hit;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_addr <= s_axi_awaddr;
    end
  end
  // results are read-only and other words are unmapped, so only the config words abort a run
  assign cfg_hit = wr_addr == 8'h00 || wr_addr == 8'h04 || wr_addr == 8'h08;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ************************************************
  // properties
  // ************************************************
  sequence write_lands;
    $rose(s_axi_bvalid) && cfg_hit && $past(conversion_busy_flag);
  endsequence
  // readies high means no register write can land on the next edge
  sequence step_ends;
    conv_done && conversion_busy_flag && s_axi_awready && s_axi_wready;
  endsequence
  AST_START_ON_BUSY: assert property ($rose(conversion_busy_flag) |-> conv_start)
    else $error("busy rose without a start");
  AST_CFG_ABORT: assert property (write_lands |-> conv_abort && !conversion_busy_flag)
    else $error("config write did not abort the run");
  AST_ABORT_IN_RUN: assert property (conv_abort |-> $past(conversion_busy_flag))
    else $error("abort while idle");
  AST_RESTART: assert property (conv_abort && conv_start |-> conversion_busy_flag)
    else $error("restart left busy low");
  AST_IRQ_ENDS_RUN: assert property (conversion_end_irq |-> $past(conv_done) &&
    $past(conversion_busy_flag) && !conversion_busy_flag)
    else $error("irq not tied to the last done");
  AST_IRQ_PULSE: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("irq longer than one cycle");
  AST_STEP_ADVANCE: assert property (step_ends |=> conv_start || conversion_end_irq)
    else $error("done neither advanced nor ended the sequence");
  AST_IDLE_DONE: assert property (!conversion_busy_flag && conv_done |=> !conversion_end_irq)
    else $error("irq from a done while idle");
  AST_BUSY_FALL: assert property ($fell(conversion_busy_flag) |-> conversion_end_irq || conv_abort)
    else $error("busy fell without irq or abort");
endmodule
bind adcets_sequencer adcets_properties chk (
  .clock(clock), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .conv_start(conv_start), .conv_abort(conv_abort), .conv_done(conv_done),
  .conversion_end_irq(conversion_end_irq), .conversion_busy_flag(conversion_busy_flag)
);
`default_nettype wire

// ---- bench/adcets_sequencer_test.sv ----
// self-checking bench for the external trigger conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcets_sequencer_test;
  logic        clock = 1'b0, reset = 1'b1, ext_trigger_in = 1'b0, slow = 1'b0, stray = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        conv_start, conv_abort, conv_done, conversion_end_irq, conversion_busy_flag;
  logic [1:0]  s_axi_bresp, s_axi_rresp, conv_channel;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, done_count;
  logic [9:0]  conv_data;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [9:0]  exp_res [4];
  int          n_fail = 0, checks = 0, n_irq = 0, i, k;
  int          seed = 32'h332b;
  adcets_sequencer dut (
    .clock(clock), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_trigger_in(ext_trigger_in), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data),
    .conversion_end_irq(conversion_end_irq), .conversion_busy_flag(conversion_busy_flag)
  );
  adcets_core_model core (
    .clock(clock), .reset(reset), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .slow(slow), .stray(stray), .conv_done(conv_done),
    .conv_data(conv_data), .done_count(done_count)
  );
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (conversion_end_irq === 1'b1) n_irq <= n_irq + 1;
  end
  // ************************************************
  // bus tasks and expectations
  // ************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(resp), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check("rresp", 32'(resp), 32'(s_axi_rresp));
  endtask
  function automatic logic fires(input logic [1:0] sel, input logic rising);
    return sel[1] || (sel[0] == rising);
  endfunction
  function automatic void predict(input logic scan, input logic buf4, input logic [1:0] ch,
                                  input int k0);
    for (int c = 0; c < 4; c++) begin
      if (scan && c <= ch) exp_res[c] = {2'(c), 8'(k0 + c)};
      else if (!scan && buf4) exp_res[c] = {ch, 8'(k0 + c)};
      else if (!scan && c == ch) exp_res[c] = {ch, 8'(k0)};
    end
  endfunction
  task automatic results();
    for (int c = 0; c < 4; c++) begin
      rd(8'(16 + 4 * c), 2'h0);
      check("result", 32'(exp_res[c]), d);
    end
  endtask
  // trigger spacing covers the whole sequence, so no edge lands mid-run by accident
  task automatic toggle_and_settle();
    @(posedge clock);
    ext_trigger_in <= ~ext_trigger_in;
    repeat (8) @(posedge clock);
    for (int j = 0; j < 400 && conversion_busy_flag === 1'b1; j++) @(posedge clock);
    // the irq counter lands one edge after busy is seen low
    @(posedge clock);
  endtask
  task automatic run_case(input logic [1:0] op, input logic [1:0] sel, input logic buf4,
                          input logic [1:0] ch, input logic [1:0] src);
    int   irq0;
    logic fire;
    wr(8'h04, {29'h0, buf4, src}, 2'h0);
    wr(8'h08, {30'h0, ch}, 2'h0);
    wr(8'h00, {26'h0, sel, op, 2'b01}, 2'h0);
    fire = fires(sel, !ext_trigger_in) && src == 2'h0;
    irq0 = n_irq;
    if (fire) predict(op[0], buf4, ch, int'(done_count));
    toggle_and_settle();
    check("irq count", 32'(irq0 + int'(fire)), 32'(n_irq));
    rd(8'h00, 2'h0);
    check("mode a", {26'h0, sel, op, 2'b01}, d);
    results();
  endtask
  task automatic mid_run(input int kind);
    int irq0;
    stray <= (kind != 0);
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    wr(8'h00, 32'h21, 2'h0);
    irq0 = n_irq;
    if (kind == 0) predict(1'b0, 1'b0, 2'h1, int'(done_count));
    @(posedge clock);
    ext_trigger_in <= ~ext_trigger_in;
    repeat (6) @(posedge clock);
    rd(8'h00, 2'h0);
    check("busy bit", 32'h1, 32'(d[1]));
    if (kind == 0) toggle_and_settle();
    else if (kind == 1) wr(8'h08, 32'h1, 2'h0);
    else wr(8'h00, 32'h20, 2'h0);
    check("busy after", 32'h0, 32'(conversion_busy_flag));
    repeat (30) @(posedge clock);
    check("irq after", 32'(irq0 + int'(kind == 0)), 32'(n_irq));
    results();
  endtask
  task automatic summarize();
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ************************************************
  // main sequence and watchdog
  // ************************************************
  initial begin
    for (i = 0; i < 4; i++) exp_res[i] = 10'h000;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 9; i++) begin
      rd(8'(4 * i), (i == 3 || i == 8) ? 2'h2 : 2'h0);
      if (i != 3 && i != 8) check("reset value", 32'h0, d);
    end
    wr(8'h20, 32'h5, 2'h2);
    wr(8'h10, 32'h3ff, 2'h0);
    for (i = 0; i < 8; i++) run_case(2'(i), 2'(i >> 1), 1'b0, 2'(i), 2'h0);
    run_case(2'h0, 2'h2, 1'b1, 2'h3, 2'h0);
    run_case(2'h2, 2'h2, 1'b1, 2'h0, 2'h0);
    run_case(2'h3, 2'h2, 1'b1, 2'h3, 2'h0);
    run_case(2'h1, 2'h2, 1'b0, 2'h0, 2'h0);
    for (i = 1; i < 4; i++) run_case(2'h0, 2'h2, 1'b0, 2'h1, 2'(i));
    slow <= 1'b1;
    for (i = 0; i < 3; i++) mid_run(i);
    k = n_irq;
    toggle_and_settle();
    check("irq disabled", 32'(k), 32'(n_irq));
    stray <= 1'b0;
    for (i = 0; i < 24; i++) begin
      slow <= 1'($random(seed));
      run_case(2'($random(seed)), 2'($random(seed)), 1'($random(seed)), 2'($random(seed)), 2'h0);
    end
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire

// ---- rtl/adcets_pkg.sv ----
// constants and types of the external trigger conversion sequencer
// What this block does
// - rising, falling or both edges are valid
// - enabled converter waits, then starts on edge
// - result stored and interrupt raised together
// - after conversion always wait for next trigger
// - busy is 1 converting, 0 waiting
// - trigger during conversion restarts the sequence
// - config write during conversion aborts to wait
// - select modes offer 1-buffer and 4-buffer storage
// - 1-buffer: one conversion, own register, interrupt
// - 4-buffer: four conversions, registers 0-3, one interrupt
// - buffer-select bit 1 picks 4-buffer variant
// - scan converts channel 0 up to selected
// - scan interrupts once after the whole range
// - clearing enable stops conversion, result discarded
// - hardware never clears the enable bit
package adcets_pkg;
  // ************************************************
  // register map (byte addresses)
  // ************************************************
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  OFF_MODE_A        = 8'h00;
  localparam logic [7:0]  OFF_MODE_C        = 8'h04;
  localparam logic [7:0]  OFF_CHANNEL_SEL   = 8'h08;
  localparam logic [7:0]  OFF_RESULT_BASE   = 8'h10;
  localparam logic [7:0]  OFF_RESULT_LAST   = 8'h1c;
  // ************************************************
  // field positions
  // ************************************************
  localparam int unsigned MA_ENABLE_BIT     = 0;
  localparam int unsigned MA_BUSY_BIT       = 1;
  localparam int unsigned MA_OP_MODE_LO     = 2;
  localparam int unsigned MA_EDGE_SEL_LO    = 4;
  localparam int unsigned MC_TRIG_SRC_LO    = 0;
  localparam int unsigned MC_BUF_SEL_BIT    = 2;
  // ************************************************
  // widths, encodings, reset values
  // ************************************************
  localparam int unsigned RESULT_W          = 10;
  localparam int unsigned NUM_RESULTS       = 4;
  localparam logic [1:0]  TRIG_SRC_EXT      = 2'h0;
  localparam logic [1:0]  EDGE_FALLING      = 2'h0;
  localparam logic [1:0]  EDGE_RISING       = 2'h1;
  localparam logic [1:0]  LAST_BUF_STEP     = 2'h3;
  localparam logic [1:0]  RST_OP_MODE       = 2'h0;
  localparam logic [1:0]  RST_EDGE_SEL      = 2'h0;
  localparam logic [1:0]  RST_TRIG_SRC      = 2'h0;
  localparam logic [1:0]  RST_CHANNEL       = 2'h0;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  // ************************************************
  // sequencer states
  // ************************************************
  typedef enum logic [1:0] {
    ADCETS_WAIT = 2'h0,
    ADCETS_RUN  = 2'h1
  } adcets_state_e;
endpackage

// ---- rtl/adcets_sequencer.sv ----
// external trigger conversion sequencer with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module adcets_sequencer (
  input  wire logic                              clock,
  input  wire logic                              reset,
  // axi4-lite slave
  input  wire logic [adcets_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output var  logic                              s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output var  logic                              s_axi_wready,
  output var  logic [1:0]                        s_axi_bresp,
  output var  logic                              s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [adcets_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output var  logic                              s_axi_arready,
  output var  logic [31:0]                       s_axi_rdata,
  output var  logic [1:0]                        s_axi_rresp,
  output var  logic                              s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // trigger pin and analog core
  input  wire logic                              ext_trigger_in,
  output var  logic                              conv_start,
  output var  logic                              conv_abort,
  output var  logic [1:0]                        conv_channel,
  input  wire logic                              conv_done,
  input  wire logic [adcets_pkg::RESULT_W-1:0]   conv_data,
  output var  logic                              conversion_end_irq,
  output var  logic                              conversion_busy_flag
);
  // ************************************************
  // state
  // ************************************************
  typedef logic [adcets_pkg::RESULT_W-1:0] adcets_result_t;

  typedef struct packed {
    // bus side
    logic [adcets_pkg::ADDR_W-1:0] awaddr;
    logic                          aw_full;
    logic                          awready;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          w_full;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    // configuration
    logic                          ce;
    logic [1:0]                    op_mode;
    logic [1:0]                    edge_sel;
    logic [1:0]                    trig_src;
    logic                          buf4;
    logic [1:0]                    chsel;
    adcets_result_t [adcets_pkg::NUM_RESULTS-1:0] result;
    // sequencer
    adcets_pkg::adcets_state_e     state;
    logic [1:0]                    step;
    logic                          start;
    logic                          abort;
    logic [1:0]                    channel;
    logic                          irq;
    logic                          busy;
  } adcets_seq_s;

  adcets_seq_s q;
  adcets_seq_s next_q;
  logic        trig;
  logic        trig_enable;
  logic        wr_fire;
  logic        wr_cfg;
  logic        wr_ok;
  logic        scan;
  logic [1:0]  store_idx;
  logic        last_step;
  logic [31:0] rd_value;
  logic        rd_ok;

  // ************************************************
  // trigger edge detection
  // ************************************************
  // edges are dropped unless enabled and in external trigger mode
  assign trig_enable = q.ce & (q.trig_src == adcets_pkg::TRIG_SRC_EXT);

  adcets_trig_edge u_edge (
    .clock          (clock),
    .reset          (reset),
    .ext_trigger_in (ext_trigger_in),
    .edge_sel       (q.edge_sel),
    .enable         (trig_enable),
    .trig_pulse     (trig)
  );

  // ************************************************
  // read decode
  // ************************************************
  always_comb begin
    rd_value = '0;
    rd_ok    = 1'b1;
    case (s_axi_araddr)
      adcets_pkg::OFF_MODE_A: begin
        rd_value[adcets_pkg::MA_ENABLE_BIT]                     = q.ce;
        rd_value[adcets_pkg::MA_BUSY_BIT]                       = q.busy;
        rd_value[adcets_pkg::MA_OP_MODE_LO +: 2]                = q.op_mode;
        rd_value[adcets_pkg::MA_EDGE_SEL_LO +: 2]               = q.edge_sel;
      end
      adcets_pkg::OFF_MODE_C: begin
        rd_value[adcets_pkg::MC_TRIG_SRC_LO +: 2]               = q.trig_src;
        rd_value[adcets_pkg::MC_BUF_SEL_BIT]                    = q.buf4;
      end
      adcets_pkg::OFF_CHANNEL_SEL: begin
        rd_value[1:0] = q.chsel;
      end
      default: begin
        if (s_axi_araddr >= adcets_pkg::OFF_RESULT_BASE &&
            s_axi_araddr <= adcets_pkg::OFF_RESULT_LAST &&
            s_axi_araddr[1:0] == 2'h0) begin
          rd_value[adcets_pkg::RESULT_W-1:0] = q.result[s_axi_araddr[3:2]];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // ************************************************
  // sequence step decode
  // ************************************************
  always_comb begin
    scan = q.op_mode[0];
    if (scan) begin
      store_idx = q.step;
      last_step = (q.step == q.chsel);
    end else if (q.buf4) begin
      store_idx = q.step;
      last_step = (q.step == adcets_pkg::LAST_BUF_STEP);
    end else begin
      store_idx = q.chsel;
      last_step = 1'b1;
    end
  end

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    next_q       = q;
    next_q.start = 1'b0;
    next_q.abort = 1'b0;
    next_q.irq   = 1'b0;
    wr_fire      = 1'b0;
    wr_cfg       = 1'b0;
    wr_ok        = 1'b1;

    // write address and data are taken in either order
    if (s_axi_awvalid && q.awready) begin
      next_q.awaddr  = s_axi_awaddr;
      next_q.aw_full = 1'b1;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.wdata  = s_axi_wdata;
      next_q.wstrb  = s_axi_wstrb;
      next_q.w_full = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      wr_fire        = 1'b1;
      next_q.aw_full = 1'b0;
      next_q.w_full  = 1'b0;
      next_q.bvalid  = 1'b1;
    end

    if (wr_fire) begin
      case (q.awaddr)
        adcets_pkg::OFF_MODE_A: begin
          wr_cfg = 1'b1;
          if (q.wstrb[0]) begin
            next_q.ce       = q.wdata[adcets_pkg::MA_ENABLE_BIT];
            next_q.op_mode  = q.wdata[adcets_pkg::MA_OP_MODE_LO +: 2];
            next_q.edge_sel = q.wdata[adcets_pkg::MA_EDGE_SEL_LO +: 2];
          end
        end
        adcets_pkg::OFF_MODE_C: begin
          wr_cfg = 1'b1;
          if (q.wstrb[0]) begin
            next_q.trig_src = q.wdata[adcets_pkg::MC_TRIG_SRC_LO +: 2];
            next_q.buf4     = q.wdata[adcets_pkg::MC_BUF_SEL_BIT];
          end
        end
        adcets_pkg::OFF_CHANNEL_SEL: begin
          wr_cfg = 1'b1;
          if (q.wstrb[0]) begin
            next_q.chsel = q.wdata[1:0];
          end
        end
        default: begin
          // results are read-only; writes to them are ignored
          wr_ok = (q.awaddr >= adcets_pkg::OFF_RESULT_BASE &&
                   q.awaddr <= adcets_pkg::OFF_RESULT_LAST &&
                   q.awaddr[1:0] == 2'h0);
        end
      endcase
      next_q.bresp = wr_ok ? adcets_pkg::RESP_OKAY : adcets_pkg::RESP_SLVERR;
    end
    next_q.awready = !next_q.aw_full;
    next_q.wready  = !next_q.w_full;

    // read channel
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid  = 1'b0;
      next_q.arready = 1'b1;
    end else if (s_axi_arvalid && q.arready) begin
      next_q.rvalid  = 1'b1;
      next_q.arready = 1'b0;
      next_q.rdata   = rd_value;
      next_q.rresp   = rd_ok ? adcets_pkg::RESP_OKAY : adcets_pkg::RESP_SLVERR;
    end

    // sequencer; the enable bit is only ever changed by software
    if (q.state == adcets_pkg::ADCETS_RUN && (!next_q.ce || wr_cfg)) begin
      // config write or disable: drop the running result
      next_q.state = adcets_pkg::ADCETS_WAIT;
      next_q.abort = 1'b1;
      next_q.step  = 2'h0;
    end else if (trig && trig_enable && !wr_cfg) begin
      // a new edge restarts from the first step, the old run is lost
      next_q.abort   = (q.state == adcets_pkg::ADCETS_RUN);
      next_q.state   = adcets_pkg::ADCETS_RUN;
      next_q.step    = 2'h0;
      next_q.start   = 1'b1;
      next_q.channel = scan ? 2'h0 : q.chsel;
    end else begin
      case (q.state)
        adcets_pkg::ADCETS_WAIT: begin
          next_q.step = 2'h0;
        end
        adcets_pkg::ADCETS_RUN: begin
          if (conv_done) begin
            next_q.result[store_idx] = conv_data;
            if (last_step) begin
              next_q.irq   = 1'b1;
              next_q.state = adcets_pkg::ADCETS_WAIT;
              next_q.step  = 2'h0;
            end else begin
              next_q.step    = q.step + 2'h1;
              next_q.start   = 1'b1;
              next_q.channel = scan ? (q.step + 2'h1) : q.chsel;
            end
          end
        end
        default: begin
          next_q.state = adcets_pkg::ADCETS_WAIT;
        end
      endcase
    end
    next_q.busy = (next_q.state == adcets_pkg::ADCETS_RUN);
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q          <= '0;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
      q.op_mode  <= adcets_pkg::RST_OP_MODE;
      q.edge_sel <= adcets_pkg::RST_EDGE_SEL;
      q.trig_src <= adcets_pkg::RST_TRIG_SRC;
      q.chsel    <= adcets_pkg::RST_CHANNEL;
      q.state    <= adcets_pkg::ADCETS_WAIT;
    end else begin
      q <= next_q;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign s_axi_awready        = q.awready;
  assign s_axi_wready         = q.wready;
  assign s_axi_bresp          = q.bresp;
  assign s_axi_bvalid         = q.bvalid;
  assign s_axi_arready        = q.arready;
  assign s_axi_rdata          = q.rdata;
  assign s_axi_rresp          = q.rresp;
  assign s_axi_rvalid         = q.rvalid;
  assign conv_start           = q.start;
  assign conv_abort           = q.abort;
  assign conv_channel         = q.channel;
  assign conversion_end_irq   = q.irq;
  assign conversion_busy_flag = q.busy;
endmodule
`default_nettype wire

// ---- rtl/adcets_trig_edge.sv ----
// trigger pin synchroniser and valid edge detector
`timescale 1ns/1ps
`default_nettype none
module adcets_trig_edge (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       ext_trigger_in,
  input  wire logic [1:0] edge_sel,
  input  wire logic       enable,
  output var  logic       trig_pulse
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pulse;
  } adcets_edge_s;

  adcets_edge_s q;
  adcets_edge_s next_q;
  logic         rise;
  logic         fall;

  always_comb begin
    next_q       = q;
    // first stage feeds only the second stage
    next_q.sync1 = ext_trigger_in;
    next_q.sync2 = q.sync1;
    next_q.prev  = q.sync2;
    rise         = q.sync2 & ~q.prev;
    fall         = ~q.sync2 & q.prev;
    case (edge_sel)
      adcets_pkg::EDGE_FALLING: next_q.pulse = enable & fall;
      adcets_pkg::EDGE_RISING:  next_q.pulse = enable & rise;
      default:                  next_q.pulse = enable & (rise | fall);
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign trig_pulse = q.pulse;
endmodule
`default_nettype wire
